// ==== logic/spisie_pkg.sv ====
// Register map, field positions, reset values and carrier types
package spisie_pkg;

   // ---------------------------------------------
   // Register byte addresses
   // ---------------------------------------------
   localparam logic [31:0] SPISIE_STAT_ADDR  = 32'h40058008;
   localparam logic [31:0] SPISIE_ENSET_ADDR = 32'h4005800c;
   localparam logic [31:0] SPISIE_ENCLR_ADDR = 32'h40058010;

   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int SPISIE_RX_AVAIL_BIT  = 0;
   localparam int SPISIE_TX_SPACE_BIT  = 1;
   localparam int SPISIE_RX_OVF_BIT    = 2;
   localparam int SPISIE_TX_STARVE_BIT = 3;
   localparam int SPISIE_FORCE_BIT     = 7;
   localparam int SPISIE_IDLE_BIT      = 8;
   localparam int SPISIE_NSRC          = 4;

   // ---------------------------------------------
   // Reset values
   // ---------------------------------------------
   localparam logic       SPISIE_RX_AVAIL_RST = 1'h0;
   localparam logic       SPISIE_TX_SPACE_RST = 1'h1;
   localparam logic       SPISIE_FLAG_RST     = 1'h0;
   localparam logic       SPISIE_FORCE_RST    = 1'h0;
   localparam logic       SPISIE_IDLE_RST     = 1'h1;
   localparam logic [3:0] SPISIE_EN_RST       = 4'h0;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic {
      SPISIE_AP_WAIT = 1'b0,
      SPISIE_AP_DONE = 1'b1
   } spisie_apb_st_t;

   // Link-side events, one cycle of the link clock each
   typedef struct packed {
      logic rx_start;
      logic rx_done;
      logic tx_need;
   } spisie_ev_t;

   typedef struct packed {
      logic [3:0] inter_frame_gap;
      logic [3:0] select_release_gap;
   } spisie_gap_t;

endpackage

// ==== logic/spisie_top.sv ====
// SPI status flags, forced end of transfer and interrupt enables
//
// Summary of operation
// - Writing one to status bit 7 forces transfer end after current activity.
// - Force bit resets 0, reads back pending, clears when transmitter goes idle.
// - Forced end still applies configured frame gap and select release gap.
// - Status bit 8 reads 1 when holding register empty and nothing shifting.
// - Enable bits sit at flag positions and all read from enable-set register.
// - Writing one to enable-set sets that enable; zero leaves it unchanged.
// - Enable 0 requests interrupt while receive data is available.
// - Enable 1 requests interrupt while transmit holding register accepts a write.
// - Enable 2 interrupts on slave receive overrun into occupied receive register.
// - Master mode withholds new transmission start while receive register is full.
// - Enable 3 interrupts on slave transmit underrun with empty holding register.
// - Writing one to enable-clear clears matching enable; zero does nothing.
// - Overrun flag sets on slave char start with full buffer; incoming data dropped.
module spisie_top
   import spisie_pkg::*;
(
   input  wire logic        pclk,            // Peripheral clock
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        psel,            // APB select
   input  wire logic        penable,         // APB enable
   input  wire logic        pwrite,          // APB direction
   input  wire logic [31:0] paddr,           // APB byte address
   input  wire logic [31:0] pwdata,          // APB write data
   output logic      [31:0] prdata,          // APB read data
   output logic             pready,          // APB ready
   output logic             pslverr,         // APB error, unmapped address
   input  wire logic        spi_clk,         // Link clock
   input  wire spisie_ev_t  link_ev,         // Link events, spi_clk domain
   input  wire logic        link_tx_busy,    // Shifter active, spi_clk domain
   input  wire logic        master_mode,     // 1 = master, 0 = slave
   input  wire logic        master_load,     // Holding register moved to shifter
   input  wire logic        tx_write,        // Software wrote transmit data
   input  wire logic        rx_read,         // Software read receive data
   input  wire spisie_gap_t gap_cfg,         // Configured gap counts
   output logic             force_end,       // Forced end pending
   output spisie_gap_t      end_gaps,        // Gaps to apply on forced end
   output logic             master_start_ok, // Master may start next frame
   output logic             irq              // Interrupt request
);

   // ---------------------------------------------
   // Link domain: events become toggles
   // ---------------------------------------------
   spisie_ev_t lk_tgl_q;
   logic       lk_busy_q;

   always_ff @(posedge spi_clk or negedge presetn) begin
      if (!presetn) begin
         lk_tgl_q <= '0;
      end else begin
         lk_tgl_q <= lk_tgl_q ^ link_ev;
      end
   end

   always_ff @(posedge spi_clk or negedge presetn) begin
      if (!presetn) begin
         lk_busy_q <= 1'b0;
      end else begin
         lk_busy_q <= link_tx_busy;
      end
   end

   // ---------------------------------------------
   // Crossing into pclk
   // ---------------------------------------------
   spisie_ev_t ev_s1_q, ev_s2_q, ev_s3_q;
   logic       busy_s1_q, busy_s2_q, busy_s3_q;
   spisie_ev_t ev_p;
   logic       busy_fall;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
         ev_s3_q <= '0;
      end else begin
         ev_s1_q <= lk_tgl_q;
         ev_s2_q <= ev_s1_q;
         ev_s3_q <= ev_s2_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
         busy_s3_q <= 1'b0;
      end else begin
         busy_s1_q <= lk_busy_q;
         busy_s2_q <= busy_s1_q;
         busy_s3_q <= busy_s2_q;
      end
   end

   assign ev_p      = ev_s2_q ^ ev_s3_q;
   assign busy_fall = busy_s3_q & ~busy_s2_q;

   // ---------------------------------------------
   // APB slave, one wait state
   // ---------------------------------------------
   spisie_apb_st_t ap_q;
   logic           wr_go, hit_stat, hit_set, hit_clr;
   logic [31:0]    rd_d;

   assign hit_stat = (paddr == SPISIE_STAT_ADDR);
   assign hit_set  = (paddr == SPISIE_ENSET_ADDR);
   assign hit_clr  = (paddr == SPISIE_ENCLR_ADDR);
   // Writes land only on the edge that completes the access
   assign wr_go    = psel & penable & pwrite & (ap_q == SPISIE_AP_DONE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ap_q <= SPISIE_AP_WAIT;
      end else begin
         case (ap_q)
            SPISIE_AP_WAIT: if (psel & penable) ap_q <= SPISIE_AP_DONE;
            SPISIE_AP_DONE: ap_q <= SPISIE_AP_WAIT;
            default:        ap_q <= SPISIE_AP_WAIT;
         endcase
      end
   end

   // ---------------------------------------------
   // Flags and control state
   // ---------------------------------------------
   logic       rx_avail_q, tx_space_q, rx_overflow_flag_q, tx_starve_flag_q;
   logic       drop_q, idle_q, force_q;
   logic [3:0] en_q;
   logic [3:0] flags;
   logic       ovf_evt, starve_evt, slave_load;

   assign ovf_evt    = ev_p.rx_start & rx_avail_q & ~master_mode;
   assign starve_evt = ev_p.tx_need & tx_space_q & ~master_mode;
   assign slave_load = ev_p.tx_need & ~tx_space_q & ~master_mode;
   assign flags      = {tx_starve_flag_q, rx_overflow_flag_q, tx_space_q, rx_avail_q};

   // Char that began on a full buffer is discarded when it completes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drop_q <= 1'b0;
      end else if (ovf_evt) begin
         drop_q <= 1'b1;
      end else if (ev_p.rx_done) begin
         drop_q <= 1'b0;
      end
   end

   // Arrival wins over a read in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_avail_q <= SPISIE_RX_AVAIL_RST;
      end else if (ev_p.rx_done & ~drop_q & ~ovf_evt) begin
         rx_avail_q <= 1'b1;
      end else if (rx_read) begin
         rx_avail_q <= 1'b0;
      end
   end

   // New software data wins over a load in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_space_q <= SPISIE_TX_SPACE_RST;
      end else if (tx_write) begin
         tx_space_q <= 1'b0;
      end else if (master_load | slave_load) begin
         tx_space_q <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_overflow_flag_q <= SPISIE_FLAG_RST;
      end else if (ovf_evt) begin
         rx_overflow_flag_q <= 1'b1;
      end else if (wr_go & hit_stat & pwdata[SPISIE_RX_OVF_BIT]) begin
         rx_overflow_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_starve_flag_q <= SPISIE_FLAG_RST;
      end else if (starve_evt) begin
         tx_starve_flag_q <= 1'b1;
      end else if (wr_go & hit_stat & pwdata[SPISIE_TX_STARVE_BIT]) begin
         tx_starve_flag_q <= 1'b0;
      end
   end

   // Request beats the idle edge, so a late write is not lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_q <= SPISIE_FORCE_RST;
      end else if (wr_go & hit_stat & pwdata[SPISIE_FORCE_BIT]) begin
         force_q <= 1'b1;
      end else if (busy_fall) begin
         force_q <= 1'b0;
      end
   end

   // Gaps captured with the request; engine honours them on the end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_gaps <= '0;
      end else if (wr_go & hit_stat & pwdata[SPISIE_FORCE_BIT]) begin
         end_gaps <= gap_cfg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_q <= SPISIE_IDLE_RST;
      end else begin
         idle_q <= tx_space_q & ~busy_s2_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= SPISIE_EN_RST;
      end else if (wr_go & hit_set) begin
         en_q <= en_q | pwdata[SPISIE_NSRC-1:0];
      end else if (wr_go & hit_clr) begin
         en_q <= en_q & ~pwdata[SPISIE_NSRC-1:0];
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & en_q);
      end
   end

   // Starting now would land a frame on a full receive register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_start_ok <= 1'b0;
      end else begin
         master_start_ok <= master_mode & ~tx_space_q & ~rx_avail_q;
      end
   end

   assign force_end = force_q;

   always_comb begin
      rd_d = 32'h00000000;
      if (hit_stat) begin
         rd_d[SPISIE_NSRC-1:0]   = flags;
         rd_d[SPISIE_FORCE_BIT]  = force_q;
         rd_d[SPISIE_IDLE_BIT]   = idle_q;
      end else if (hit_set) begin
         rd_d[SPISIE_NSRC-1:0]   = en_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= '0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= rd_d;
         pready  <= psel & penable & (ap_q == SPISIE_AP_WAIT);
         pslverr <= psel & penable & (ap_q == SPISIE_AP_WAIT) & ~(hit_stat | hit_set | hit_clr);
      end
   end

   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_force_wr;
      wr_go & hit_stat & pwdata[SPISIE_FORCE_BIT];
   endsequence

   sequence s_full_start;
      ev_p.rx_start & rx_avail_q & ~master_mode;
   endsequence

   property p_force_set;
      s_force_wr |=> force_end ##0 (end_gaps == $past(gap_cfg));
   endproperty
   a_force_set: assert property (p_force_set) else $error("force end not taken");

   property p_force_clr;
      busy_fall & ~(wr_go & hit_stat & pwdata[SPISIE_FORCE_BIT]) |=> !force_end;
   endproperty
   a_force_clr: assert property (p_force_clr) else $error("force end not cleared");

   property p_idle;
      tx_space_q & ~busy_s2_q ##1 tx_space_q & ~busy_s2_q |=> idle_q;
   endproperty
   a_idle: assert property (p_idle) else $error("idle flag low while idle");
   property p_enset;
      wr_go & hit_set |=> (en_q & $past(pwdata[3:0] | en_q)) == $past(pwdata[3:0] | en_q);
   endproperty
   a_enset: assert property (p_enset) else $error("enable set wrong");
   property p_enclr;
      wr_go & hit_clr |=> (en_q == ($past(en_q) & ~$past(pwdata[3:0])));
   endproperty
   a_enclr: assert property (p_enclr) else $error("enable clear wrong");

   property p_irq_rx;
      en_q[0] & rx_avail_q |=> irq;
   endproperty
   a_irq_rx: assert property (p_irq_rx) else $error("rx irq missing");

   property p_irq_none;
      (flags & en_q) == 4'h0 |=> !irq;
   endproperty
   a_irq_none: assert property (p_irq_none) else $error("spurious irq");

   // A read in the same cycle may legally empty the buffer
   property p_ovf;
      s_full_start ##0 !rx_read |=> rx_overflow_flag_q & rx_avail_q;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overrun not flagged");
   property p_master_hold;
      rx_avail_q |=> !master_start_ok;
   endproperty
   a_master_hold: assert property (p_master_hold) else $error("start with full rx");
   property p_starve;
      ev_p.tx_need & tx_space_q & ~master_mode |=> tx_starve_flag_q;
   endproperty
   a_starve: assert property (p_starve) else $error("underrun not flagged");

endmodule

// ==== tb/spisie_link_model.sv ====
// Link-side partner: shift engine events and busy level in the link clock domain
module spisie_link_model
   import spisie_pkg::*;
(
   spi_clk,       // Link clock
   link_ev,       // Event pulses
   link_tx_busy   // Shifter active
);
   timeunit 1ns;
   timeprecision 100ps;
   input  wire logic spi_clk;
   output spisie_ev_t link_ev;
   output logic       link_tx_busy;

   initial begin
      link_ev      = '0;
      link_tx_busy = 1'b0;
   end

   // ---------------------------------------------
   // Requests, one link cycle each
   // ---------------------------------------------
   // Mask order: rx_start, rx_done, tx_need
   task automatic pulse(input logic [2:0] m);
      @(posedge spi_clk);
      link_ev <= spisie_ev_t'(m);
      @(posedge spi_clk);
      link_ev <= '0;
   endtask

   // Busy is a level; holding it lets a forced end wait for the shifter
   task automatic busy(input logic v);
      @(posedge spi_clk);
      link_tx_busy <= v;
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for SPI status, forced end and interrupt enables
module tb_top
   import spisie_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        pclk, presetn, psel, penable, pwrite, spi_clk, er;
   logic        master_mode, master_load, tx_write, rx_read;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic        pready, pslverr, force_end, master_start_ok, irq, link_tx_busy;
   spisie_ev_t  link_ev;
   spisie_gap_t gap_cfg, end_gaps;
   int          err_total = 0;
   int          samples_checked = 0;

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Link clock, phase unrelated to pclk
   initial begin
      spi_clk = 1'b0;
      #1.3;
      forever #3 spi_clk = ~spi_clk;
   end

   spisie_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .spi_clk(spi_clk), .link_ev(link_ev), .link_tx_busy(link_tx_busy), .master_mode(master_mode),
      .master_load(master_load), .tx_write(tx_write), .rx_read(rx_read), .gap_cfg(gap_cfg),
      .force_end(force_end), .end_gaps(end_gaps), .master_start_ok(master_start_ok), .irq(irq));
   spisie_link_model LINK (.spi_clk(spi_clk), .link_ev(link_ev), .link_tx_busy(link_tx_busy));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t no bus answer", $time);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string m);
      apb(1'b0, a, 32'h0);
      chk(rd, e, m);
   endtask
   // Poll status under a bounded count; link events cross clock domains
   task automatic wait_stat(input logic [31:0] mk, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, SPISIE_STAT_ADDR, 32'h0);
         n++;
      end while ((rd & mk) !== v && n < 20);
      chk(rd & mk, v, "status field");
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // Mask order: master_load, tx_write, rx_read
   task automatic strobe(input logic [2:0] m);
      @(posedge pclk);
      {master_load, tx_write, rx_read} <= m;
      @(posedge pclk);
      {master_load, tx_write, rx_read} <= 3'h0;
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      rd_chk(SPISIE_STAT_ADDR, 32'h102, "status reset");
      chk(er, 1'b0, "mapped no error");
      rd_chk(SPISIE_ENSET_ADDR, 32'h0, "enables reset");
      rd_chk(SPISIE_ENCLR_ADDR + 32'h4, 32'h0, "unmapped read");
      chk(er, 1'b1, "unmapped error");
      chk(irq, 1'b0, "irq reset");
      $display("test reset done");
   endtask
   task automatic t_enables();
      apb(1'b1, SPISIE_ENSET_ADDR, 32'hf);
      rd_chk(SPISIE_ENSET_ADDR, 32'hf, "set all");
      apb(1'b1, SPISIE_ENSET_ADDR, 32'h0);
      rd_chk(SPISIE_ENSET_ADDR, 32'hf, "zero keeps");
      apb(1'b1, SPISIE_ENCLR_ADDR, 32'h5);
      rd_chk(SPISIE_ENSET_ADDR, 32'ha, "clear some");
      cyc(3);
      chk(irq, 1'b1, "tx space irq");
      apb(1'b1, SPISIE_ENCLR_ADDR, 32'h2);
      cyc(3);
      chk(irq, 1'b0, "no flag enabled");
      apb(1'b1, SPISIE_ENCLR_ADDR, 32'hf);
      $display("test enables done");
   endtask
   task automatic t_rx();
      apb(1'b1, SPISIE_ENSET_ADDR, 32'h1);
      LINK.pulse(3'b010);
      wait_stat(32'h1, 32'h1);
      cyc(3);
      chk(irq, 1'b1, "rx irq");
      LINK.pulse(3'b100);
      LINK.pulse(3'b010);
      wait_stat(32'h5, 32'h5);
      apb(1'b1, SPISIE_ENSET_ADDR, 32'h4);
      apb(1'b1, SPISIE_ENCLR_ADDR, 32'h1);
      cyc(3);
      chk(irq, 1'b1, "overrun irq");
      apb(1'b1, SPISIE_STAT_ADDR, 32'h4);
      strobe(3'b001);
      wait_stat(32'h5, 32'h0);
      cyc(3);
      chk(irq, 1'b0, "overrun cleared");
      apb(1'b1, SPISIE_ENCLR_ADDR, 32'hf);
      $display("test receive done");
   endtask
   task automatic t_tx();
      apb(1'b1, SPISIE_ENSET_ADDR, 32'h8);
      LINK.pulse(3'b001);
      wait_stat(32'h8, 32'h8);
      cyc(3);
      chk(irq, 1'b1, "underrun irq");
      apb(1'b1, SPISIE_STAT_ADDR, 32'h8);
      wait_stat(32'h8, 32'h0);
      cyc(3);
      chk(irq, 1'b0, "underrun cleared");
      apb(1'b1, SPISIE_ENCLR_ADDR, 32'hf);
      $display("test underrun done");
   endtask
   task automatic t_force();
      int n;
      gap_cfg <= 8'h5a;
      LINK.busy(1'b1);
      cyc(6);
      apb(1'b1, SPISIE_STAT_ADDR, 32'h80);
      // Gaps change after the request; the captured copy must not follow
      gap_cfg <= 8'hc3;
      cyc(2);
      chk(force_end, 1'b1, "force pending");
      chk(end_gaps, 8'h5a, "gaps kept");
      wait_stat(32'h80, 32'h80);
      cyc(10);
      chk(force_end, 1'b1, "waits for shifter");
      LINK.busy(1'b0);
      n = 0;
      while (force_end !== 1'b0 && n < 20) begin
         cyc(1);
         n++;
      end
      chk(force_end, 1'b0, "force cleared at idle");
      wait_stat(32'h180, 32'h100);
      $display("test force end done");
   endtask
   task automatic t_idle();
      master_mode <= 1'b1;
      strobe(3'b010);
      wait_stat(32'h102, 32'h0);
      cyc(2);
      chk(master_start_ok, 1'b1, "start allowed");
      LINK.pulse(3'b010);
      wait_stat(32'h1, 32'h1);
      cyc(2);
      chk(master_start_ok, 1'b0, "start withheld");
      strobe(3'b001);
      strobe(3'b100);
      LINK.busy(1'b1);
      wait_stat(32'h102, 32'h2);
      LINK.busy(1'b0);
      wait_stat(32'h102, 32'h102);
      $display("test idle done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0; pwdata = 32'h0;
      master_mode = 1'b0; master_load = 1'b0; tx_write = 1'b0; rx_read = 1'b0; gap_cfg = 8'ha5;
      cyc(8);
      presetn <= 1'b1;
      t_reset();
      t_enables();
      t_rx();
      t_tx();
      t_force();
      t_idle();
      summarize();
   end
   initial begin
      cyc(20000);
      err_total++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end
endmodule
